// file: src/sleep_power_map.svh
`ifndef SLEEP_POWER_MAP_SVH
`define SLEEP_POWER_MAP_SVH
// How it works
// (R1) Software detector disable acts on sleep entry
// (R2) Detector re-enabled automatically on every wake
// (R3) Wake delay stretched to 60 us
// (R4) Disable bit affects Power-down and Standby only
// (R5) Disable bit written only via unlock sequence
// (R6) Software sets both bits, then disable alone
// (R7) Disable active after three cycles, clears after three
// (R8) Gated peripheral state is frozen
// (R9) Gated peripheral registers blocked, resources kept
// (R10) Clearing gate bit resumes peripheral unchanged
// (R11) Gating acts in Active and Idle only
// (R12) Comparator off in all sleeps except Idle
// (R13) Internal reference kept for comparator unless disabled
// (R14) Reference on only when detector or comparator needs
// (R15) Fuse-enabled detector stays on during sleep
// (R16) Enabled watchdog keeps running in sleep
// (R17) Input buffers off when I/O clock stopped, except wake pins
// (R18) Software may disable individual input buffers
// (R19) Mode bits 6 and 4 select sleep mode
// (R20) Sleep only while sleep enable bit set
// (R21) Standby advised only with crystal clock
// (R22) Gating register bits 7..4 read zero
// (R23) Bits 3 and 2 stop wide and narrow timers
// (R24) Bit 1 stops universal serial interface
// (R25) Bit 0 stops asynchronous serial module
// (R26) Detector control at 0x07, upper bits zero
// (R27) One-cycle sleep request acted on when enabled
// (R28) Clock gate enables are registered glitch-free

`define DET_CTRL_ADDR 8'h07
`define CORE_CTRL_ADDR 8'h35
`define GATING_ADDR 8'h36
`define INBUF_ADDR 8'h37
`define SLEEP_STATUS_ADDR 8'h38
`define DET_CTRL_RESET 8'h00
`define CORE_CTRL_RESET 8'h00
`define GATING_RESET 8'h00
`define INBUF_RESET 8'h00
`define BIT_SELECT_HIGH 6
`define BIT_SLEEP_ENABLE 5
`define BIT_SELECT_LOW 4
`define BIT_DISABLE 1
`define BIT_UNLOCK 0
`define GATING_MASK 8'h0f
`define DET_CTRL_MASK 8'h03
`define UNLOCK_WINDOW 3'd4
`define ARM_DELAY 3'd3
`define ACTIVE_SPAN 3'd3
`define CLK_MHZ 200
`define WAKE_DELAY_US 60
`define WAKE_DELAY_CYCLES (`WAKE_DELAY_US * `CLK_MHZ)
`endif

// file: src/sleep_power_pkg.sv
package sleep_power_pkg;
	typedef enum logic [1:0] {
		mode_idle,
		mode_power_down,
		mode_standby
	} sleep_mode_t;
	typedef enum logic [1:0] {
		st_run,
		st_sleep,
		st_wake
	} sleep_state_t;
endpackage : sleep_power_pkg

// file: src/sleep_power_gating_control.sv
`include "sleep_power_map.svh"

module sleep_power_gating_control
	import sleep_power_pkg::*;
#(
	parameter int WAKE_CYCLES = `WAKE_DELAY_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Processor core.
	input wire logic sleep_req_i,
	input wire logic wake_i,
	output logic cpu_clk_en_o,
	output logic sleeping_o,
	// Analog and system state.
	input wire logic detector_fuse_en_i,
	input wire logic comparator_off_i,
	input wire logic comparator_refsel_i,
	input wire logic watchdog_en_i,
	input wire logic [7:0] wake_pin_mask_i,
	output logic detector_en_o,
	output logic reference_en_o,
	output logic comparator_en_o,
	output logic watchdog_run_o,
	output logic [7:0] input_buf_en_o,
	// Peripheral clock and register access enables.
	output logic timer_wide_clk_en_o,
	output logic timer_narrow_clk_en_o,
	output logic universal_serial_clk_en_o,
	output logic async_serial_clk_en_o,
	output logic [3:0] periph_access_en_o
);

	logic [7:0] core_ctrl_reg;
	logic [7:0] gating_reg;
	logic [7:0] inbuf_dis_reg;
	logic unlock_reg;
	logic [2:0] unlock_cnt_reg;
	logic [2:0] arm_cnt_reg;
	logic [2:0] active_cnt_reg;
	logic disable_active_reg;
	logic det_off_reg;
	logic long_wake_reg;
	logic [31:0] wake_cnt_reg;
	sleep_state_t state_reg;
	sleep_mode_t mode_reg;

	function automatic sleep_mode_t decode_mode(input logic [7:0] ctrl);
		unique case ({ctrl[`BIT_SELECT_HIGH], ctrl[`BIT_SELECT_LOW]})
			2'b00: decode_mode = mode_idle;
			2'b10: decode_mode = mode_standby;
			default: decode_mode = mode_power_down;
		endcase
	endfunction : decode_mode

	function automatic logic reg_hit(input logic [7:0] addr,
		input logic [7:0] target);
		reg_hit = addr == target;
	endfunction : reg_hit

	wire sleep_mode_t sel_mode = decode_mode(core_ctrl_reg); // (R19)
	wire wr_det = wr_i && reg_hit(addr_i, `DET_CTRL_ADDR);
	wire wr_core = wr_i && reg_hit(addr_i, `CORE_CTRL_ADDR);
	wire wr_gate = wr_i && reg_hit(addr_i, `GATING_ADDR);
	wire wr_inbuf = wr_i && reg_hit(addr_i, `INBUF_ADDR);
	wire unlock_write = wr_det && wdata_i[`BIT_DISABLE]
		&& wdata_i[`BIT_UNLOCK];
	// Second step of the sequence must arrive while unlock is open.
	wire disable_write = wr_det && unlock_reg && wdata_i[`BIT_DISABLE]
		&& !wdata_i[`BIT_UNLOCK]; // (R5) (R6)
	wire disable_pending = arm_cnt_reg != 3'd0;
	wire disable_bit = disable_pending || disable_active_reg;
	// Sleep is honoured only with sleep enable set.
	wire go_sleep = state_reg == st_run && sleep_req_i
		&& core_ctrl_reg[`BIT_SLEEP_ENABLE]; // (R20) (R27)
	wire deep_mode = sel_mode != mode_idle;
	wire sw_det_off = disable_active_reg && deep_mode; // (R4) (R7)
	wire in_sleep = state_reg == st_sleep;
	wire sleep_deep = in_sleep && mode_reg != mode_idle;
	wire wake_done = state_reg == st_wake && wake_cnt_reg == 32'd0;
	// Gate bits only matter in Active and Idle; deep sleep stops all.
	wire [3:0] clk_on = sleep_deep ? 4'h0 : ~gating_reg[3:0]; // (R11)
	wire det_on_next = detector_fuse_en_i && !det_off_reg; // (R15)
	wire cmp_on_next = !comparator_off_i && !sleep_deep; // (R12)
	wire ref_on_next = det_on_next
		|| (!comparator_off_i && comparator_refsel_i); // (R13) (R14)
	wire [7:0] inbuf_next = sleep_deep
		? (wake_pin_mask_i & ~inbuf_dis_reg)
		: ~inbuf_dis_reg; // (R17) (R18)

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			core_ctrl_reg <= `CORE_CTRL_RESET;
		else if (wr_core)
			core_ctrl_reg <= wdata_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			gating_reg <= `GATING_RESET;
		else if (wr_gate)
			gating_reg <= wdata_i & `GATING_MASK; // (R22)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			inbuf_dis_reg <= `INBUF_RESET;
		else if (wr_inbuf)
			inbuf_dis_reg <= wdata_i;
	end

	// Unlock window: open for four cycles after the first write.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			unlock_reg <= 1'b0;
			unlock_cnt_reg <= 3'd0;
		end
		else if (unlock_write && !unlock_reg)
		begin
			unlock_reg <= 1'b1;
			unlock_cnt_reg <= `UNLOCK_WINDOW;
		end
		else if (disable_write || unlock_cnt_reg == 3'd1)
		begin
			unlock_reg <= 1'b0;
			unlock_cnt_reg <= 3'd0;
		end
		else if (unlock_cnt_reg != 3'd0)
			unlock_cnt_reg <= unlock_cnt_reg - 3'd1;
	end

	// Disable bit arms three cycles after set, then lives three cycles.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			arm_cnt_reg <= 3'd0;
			active_cnt_reg <= 3'd0;
			disable_active_reg <= 1'b0;
		end
		else if (disable_write)
		begin
			arm_cnt_reg <= `ARM_DELAY;
			active_cnt_reg <= 3'd0;
			disable_active_reg <= 1'b0;
		end
		else if (arm_cnt_reg == 3'd1)
		begin
			arm_cnt_reg <= 3'd0;
			disable_active_reg <= 1'b1;
			active_cnt_reg <= `ACTIVE_SPAN;
		end
		else if (arm_cnt_reg != 3'd0)
			arm_cnt_reg <= arm_cnt_reg - 3'd1;
		else if (active_cnt_reg == 3'd1)
		begin
			active_cnt_reg <= 3'd0;
			disable_active_reg <= 1'b0; // (R7)
		end
		else if (active_cnt_reg != 3'd0)
			active_cnt_reg <= active_cnt_reg - 3'd1;
	end

	// Sleep sequencer.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= st_run;
			mode_reg <= mode_idle;
			det_off_reg <= 1'b0;
			long_wake_reg <= 1'b0;
			wake_cnt_reg <= 32'd0;
		end
		else
		begin
			unique case (state_reg)
				st_run:
					if (go_sleep)
					begin
						state_reg <= st_sleep;
						mode_reg <= sel_mode;
						det_off_reg <= sw_det_off; // (R1)
						long_wake_reg <= sw_det_off;
					end
				st_sleep:
					if (wake_i)
					begin
						state_reg <= st_wake;
						det_off_reg <= 1'b0; // (R2)
						// The detector needs time to settle after restart.
						wake_cnt_reg <= long_wake_reg
							? WAKE_CYCLES[31:0] : 32'd0; // (R3)
					end
				st_wake:
					if (wake_done)
						state_reg <= st_run;
					else
						wake_cnt_reg <= wake_cnt_reg - 32'd1;
			endcase
		end
	end

	// All outputs registered so enables change only on clock edges.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cpu_clk_en_o <= 1'b1;
		else
			cpu_clk_en_o <= state_reg == st_run && !go_sleep;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			sleeping_o <= 1'b0;
		else
			sleeping_o <= state_reg != st_run || go_sleep;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			detector_en_o <= 1'b0;
		else
			detector_en_o <= det_on_next;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			reference_en_o <= 1'b0;
		else
			reference_en_o <= ref_on_next;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			comparator_en_o <= 1'b0;
		else
			comparator_en_o <= cmp_on_next;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_run_o <= 1'b0;
		else
			watchdog_run_o <= watchdog_en_i; // (R16)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			input_buf_en_o <= 8'hff;
		else
			input_buf_en_o <= inbuf_next;
	end

	// Stopped clock holds peripheral state; restart resumes it.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_wide_clk_en_o <= 1'b1;
		else
			timer_wide_clk_en_o <= clk_on[3]; // (R8) (R10) (R23) (R28)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			timer_narrow_clk_en_o <= 1'b1;
		else
			timer_narrow_clk_en_o <= clk_on[2]; // (R23)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			universal_serial_clk_en_o <= 1'b1;
		else
			universal_serial_clk_en_o <= clk_on[1]; // (R24)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			async_serial_clk_en_o <= 1'b1;
		else
			async_serial_clk_en_o <= clk_on[0]; // (R25)
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			periph_access_en_o <= 4'hf;
		else
			periph_access_en_o <= ~gating_reg[3:0]; // (R9)
	end

	// Read data appear in the cycle after the read strobe.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (rd_i)
		begin
			unique case (addr_i)
				`DET_CTRL_ADDR: rdata_o <= {6'h00, disable_bit,
					unlock_reg}; // (R26)
				`CORE_CTRL_ADDR: rdata_o <= core_ctrl_reg;
				`GATING_ADDR: rdata_o <= gating_reg; // (R22)
				`INBUF_ADDR: rdata_o <= inbuf_dis_reg;
				`SLEEP_STATUS_ADDR: rdata_o <= {4'h0, long_wake_reg,
					det_off_reg, state_reg};
				default: rdata_o <= 8'h00;
			endcase
		end
		else
			rdata_o <= 8'h00;
	end

endmodule : sleep_power_gating_control

// file: bench/sleep_ctl_props.sv
`include "sleep_power_map.svh"

module sleep_ctl_props
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Core and analog state.
	input wire logic sleep_req_i,
	input wire logic sleeping_o,
	input wire logic watchdog_en_i,
	input wire logic watchdog_run_o,
	input wire logic detector_fuse_en_i,
	input wire logic comparator_off_i,
	input wire logic comparator_refsel_i,
	input wire logic detector_en_o,
	input wire logic reference_en_o,
	// Gating outputs.
	input wire logic async_serial_clk_en_o,
	input wire logic [3:0] periph_access_en_o,
	input wire logic [7:0] input_buf_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_gate_reserved_zero:
		assert property ($past(rd_i) && $past(addr_i) == `GATING_ADDR
			|-> rdata_o[7:4] == 4'h0) else $error("gating top bits set");
	a_detctl_upper_zero:
		assert property ($past(rd_i) && $past(addr_i) == `DET_CTRL_ADDR
			|-> rdata_o[7:2] == 6'h00) else $error("detector top bits set");
	a_sleep_after_req:
		assert property ($rose(sleeping_o)
			|-> $past(sleep_req_i) || $past(sleep_req_i, 2))
			else $error("sleep without request");
	a_watchdog_follows:
		assert property (watchdog_run_o == $past(watchdog_en_i))
			else $error("watchdog run wrong");
	a_ref_for_comp:
		assert property ($past(comparator_refsel_i && !comparator_off_i)
			|-> reference_en_o) else $error("reference dropped");
	a_ref_off_unneeded:
		assert property ($past(!detector_fuse_en_i && (comparator_off_i
			|| !comparator_refsel_i)) |-> !reference_en_o)
			else $error("reference left on");
	a_det_fuse_off:
		assert property (!$past(detector_fuse_en_i) |-> !detector_en_o)
			else $error("detector on without fuse");
	a_usart_clk_gate:
		assert property ($past(wr_i, 2) && $past(addr_i, 2) == `GATING_ADDR
			&& !sleeping_o |-> async_serial_clk_en_o == !$past(wdata_i[0], 2))
			else $error("async serial clock wrong");
	a_access_block:
		assert property ($past(wr_i, 2) && $past(addr_i, 2) == `GATING_ADDR
			|-> periph_access_en_o == ~$past(wdata_i[3:0], 2))
			else $error("access enable wrong");
	a_inbuf_disable:
		assert property ($past(wr_i, 2) && $past(addr_i, 2) == `INBUF_ADDR
			&& !sleeping_o |-> input_buf_en_o == ~$past(wdata_i, 2))
			else $error("input buffer enable wrong");
endmodule : sleep_ctl_props

// file: bench/core_model.sv
module core_model
(
	input wire logic clk_i,
	output logic sleep_req_o,
	output logic wake_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sleep_req_o = 1'b0;
		wake_o = 1'b0;
	end
	// The sleep instruction lasts exactly one cycle.
	task automatic pulse_sleep();
		@(posedge clk_i);
		sleep_req_o <= 1'b1;
		@(posedge clk_i);
		sleep_req_o <= 1'b0;
	endtask : pulse_sleep
	task automatic pulse_wake();
		@(posedge clk_i);
		wake_o <= 1'b1;
		@(posedge clk_i);
		wake_o <= 1'b0;
	endtask : pulse_wake
endmodule : core_model

// file: bench/tb_top.sv
`include "sleep_power_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WAKE = 20;
	logic clk_i, rst_i, wr_i, rd_i, fuse, cmp_off, refsel, wdog;
	logic [7:0] addr_i, wdata_i, rdata, inbuf;
	logic cpu_en, sleeping, det_en, ref_en, cmp_en, wd_run, sreq, wake;
	logic tw, tn, tu, ta;
	logic [3:0] acc;
	int n_mismatch = 0;
	int samples_checked = 0;

	sleep_power_gating_control #(.WAKE_CYCLES(WAKE)) dut_u (.clk_i(clk_i),
		.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata), .sleep_req_i(sreq), .wake_i(wake),
		.cpu_clk_en_o(cpu_en), .sleeping_o(sleeping),
		.detector_fuse_en_i(fuse), .comparator_off_i(cmp_off),
		.comparator_refsel_i(refsel), .watchdog_en_i(wdog),
		.wake_pin_mask_i(8'h0c), .detector_en_o(det_en),
		.reference_en_o(ref_en), .comparator_en_o(cmp_en),
		.watchdog_run_o(wd_run), .input_buf_en_o(inbuf),
		.timer_wide_clk_en_o(tw), .timer_narrow_clk_en_o(tn),
		.universal_serial_clk_en_o(tu), .async_serial_clk_en_o(ta),
		.periph_access_en_o(acc));
	core_model core_u (.clk_i(clk_i), .sleep_req_o(sreq), .wake_o(wake));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd
	// Unlock, arm the disable, sleep gap cycles later (inside its active span for gap 2), then wake.
	task automatic nap(input logic [7:0] ctl, input logic [7:0] st,
		input logic [7:0] bufs, input int lo, input int hi, input int gap);
		int n;
		n = 0;
		wr(`CORE_CTRL_ADDR, ctl);
		wr(`DET_CTRL_ADDR, 8'h03);
		wr(`DET_CTRL_ADDR, 8'h02);
		repeat (gap) @(posedge clk_i);
		core_u.pulse_sleep();
		repeat (4) @(posedge clk_i);
		#1;
		chk({det_en, sleeping, cmp_en, ref_en, wd_run, tw, 2'b00}, st);
		chk(inbuf, bufs);
		core_u.pulse_wake();
		while (cpu_en !== 1'b1 && n < 100)
		begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h0, n >= lo && n <= hi}, 8'h01);
		chk({7'h0, det_en}, 8'h01);
		wr(`CORE_CTRL_ADDR, 8'h00);
	endtask : nap
	task automatic scen_regs();
		rd(`DET_CTRL_ADDR, 8'h00);
		rd(`CORE_CTRL_ADDR, 8'h00);
		rd(`INBUF_ADDR, 8'h00);
		wr(`DET_CTRL_ADDR, 8'h02);
		rd(`DET_CTRL_ADDR, 8'h00);
		wr(`DET_CTRL_ADDR, 8'h03);
		rd(`DET_CTRL_ADDR, 8'h01);
		wr(`DET_CTRL_ADDR, 8'h02);
		rd(`DET_CTRL_ADDR, 8'h02);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
	endtask : scen_regs
	task automatic scen_gate();
		wr(`GATING_ADDR, 8'hff);
		rd(`GATING_ADDR, 8'h0f);
		chk({tw, tn, tu, ta, acc}, 8'h00);
		wr(`GATING_ADDR, 8'h00);
		rd(`GATING_ADDR, 8'h00);
		chk({tw, tn, tu, ta, acc}, 8'hff);
		wr(`INBUF_ADDR, 8'h81);
		rd(`INBUF_ADDR, 8'h81);
		chk(inbuf, 8'h7e);
		wr(`INBUF_ADDR, 8'h00);
	endtask : scen_gate
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		n_mismatch++;
		final_report();
	end
	initial
	begin
		rst_i = 1'b1;
		{wr_i, rd_i, fuse, cmp_off, refsel, wdog} = 6'b001100;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		scen_regs();
		scen_gate();
		@(posedge clk_i);
		cmp_off <= 1'b0;
		refsel <= 1'b1;
		wdog <= 1'b1;
		nap(8'h30, 8'h58, 8'h0c, WAKE, WAKE + 8, 2);
		nap(8'h20, 8'hfc, 8'hff, 0, 6, 2);
		nap(8'h60, 8'h58, 8'h0c, WAKE, WAKE + 8, 2);
		nap(8'h70, 8'h58, 8'h0c, WAKE, WAKE + 8, 2);
		nap(8'h30, 8'hd8, 8'h0c, 0, 6, 8);
		wr(`CORE_CTRL_ADDR, 8'h10);
		core_u.pulse_sleep();
		repeat (4) @(posedge clk_i);
		#1;
		chk({7'h0, sleeping}, 8'h00);
		@(posedge clk_i);
		fuse <= 1'b0;
		cmp_off <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk({6'h0, det_en, ref_en}, 8'h00);
		final_report();
	end
endmodule : tb_top

bind sleep_power_gating_control sleep_ctl_props chk_u (.clk_i(clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .sleep_req_i(sleep_req_i),
	.sleeping_o(sleeping_o), .watchdog_en_i(watchdog_en_i),
	.watchdog_run_o(watchdog_run_o), .detector_fuse_en_i(detector_fuse_en_i),
	.comparator_off_i(comparator_off_i),
	.comparator_refsel_i(comparator_refsel_i),
	.detector_en_o(detector_en_o), .reference_en_o(reference_en_o),
	.async_serial_clk_en_o(async_serial_clk_en_o),
	.periph_access_en_o(periph_access_en_o),
	.input_buf_en_o(input_buf_en_o));
